// *** rtl/bmcfg_pkg.sv ***
// Purpose: constants for the bus and media option register bank
// Assumes: 32-bit axi4-lite data, 16-bit register in the low half
// Notes: offsets are byte addresses
package bmcfg_pkg;
  localparam logic [3:0] BMCFG_OFF_CFG = 4'h0;
  localparam logic [3:0] BMCFG_OFF_STAT = 4'h4;
  localparam int BMCFG_ADDR_W = 4;
  localparam int BMCFG_B_MEDIA_SELECT = 0;
  localparam int BMCFG_B_WAKE = 2;
  localparam int BMCFG_B_CONVDESEL = 5;
  localparam int BMCFG_B_NOSTAG = 6;
  localparam int BMCFG_B_IRQSTYLE = 7;
  localparam int BMCFG_B_UNLOCK = 8;
  localparam logic [15:0] BMCFG_RST_CFG = 16'h0002;
  localparam logic [15:0] BMCFG_WR_MASK = 16'h0167;
  localparam logic [1:0] BMCFG_RESP_OKAY = 2'h0;
  localparam logic [1:0] BMCFG_RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    BMCFG_MED_SOFT = 2'b00,
    BMCFG_MED_TP = 2'b01,
    BMCFG_MED_AUTO = 2'b10,
    BMCFG_MED_AUI = 2'b11
  } bmcfg_med_t;
endpackage

// *** rtl/bmcfg_sync2.sv ***
// Purpose: two flip-flop synchroniser for a vector of levels
// Assumes: inputs are slow levels from outside the clock domain
// Notes: first stage feeds only the second stage
`timescale 1ns/1ns
`default_nettype none
module bmcfg_sync2 #(
  parameter int W = 1
) (
  input wire logic sys_clk, // system clock
  input wire logic rst_n, // synchronised reset, active low
  input wire logic ce, // clock enable
  input wire logic [W-1:0] din, // asynchronous levels
  output logic [W-1:0] dout // synchronised levels
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s1_d;
  logic [W-1:0] s2_d;
  // next values hold while clock enable is low
  always_comb begin
    s1_d = ce ? din : s1_q;
    s2_d = ce ? s1_q : dout;
  end
  // two stage register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= '0;
      dout <= '0;
    end else begin
      s1_q <= s1_d;
      dout <= s2_d;
    end
  end
endmodule
`default_nettype wire

// *** rtl/bmcfg_top.sv ***
// Purpose: bus and media option bits behind an axi4-lite slave
// Assumes: pins from outside are synchronised here; 100 MHz sys_clk
// Notes: the config word sits at offset 0, live status at offset 4
`timescale 1ns/1ns
`default_nettype none
// Function
// R1 - with write unlock clear, block station address store and flash writes
// R2 - bit 7 is read-only: one for level interrupts, zero for edge
// R3 - no-stagger zero staggers data drive behind address in bus master
// R4 - no-stagger one drives data and address together; resets to zero
// R5 - converter deselect one drives converter select to deselected
// R6 - deselect zero with aui active enables the dc-dc converter
// R7 - wake enable one keeps twisted-pair receiver alive in sleep
// R8 - link indicator shows twisted-pair link, active when link passes
// R9 - wake enable zero disables wake; only meaningful with twisted pair
// R10 - media select 00 mode reg, 01 tp, 10 auto default, 11 aui
module bmcfg_top
  import bmcfg_pkg::*;
#(
  parameter int ADDR_W = BMCFG_ADDR_W
) (
  input wire logic sys_clk, // system clock
  input wire logic nrst, // asynchronous reset, active low
  input wire logic ce, // clock enable, freezes state when low
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic irq_level_strap, // pin: high selects level interrupts
  input wire logic link_pass, // pin: twisted-pair link passes
  input wire logic sleep_req, // pin: device in sleep
  input wire logic mode_reg_aui, // same clock: mode register picks aui
  input wire logic auto_aui, // same clock: auto select chose aui
  input wire logic bus_master, // same clock: bus master cycle running
  input wire logic prom_wr_req, // same clock: address store write request
  input wire logic flash_wr_req, // same clock: flash write request
  output logic prom_wr_en, // gated address store write strobe
  output logic flash_wr_en, // gated flash write strobe
  output logic data_drive_stagger, // data drive lags address drive
  output logic converter_select_out, // low enables dc-dc converter
  output logic tp_rx_sleep_on, // keep tp receiver on during sleep
  output logic link_indicator, // link status, active low
  output logic aui_active, // aui is the active medium
  output logic [1:0] media_select // current media select field
);
  // reset release through two flip-flops
  logic rst_s1_q;
  logic rst_n;

  // the first flip-flop feeds only the second, so release is clean
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end

  // pin inputs synchronised
  logic [2:0] pins_s;
  bmcfg_sync2 #(.W(3)) u_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .ce(ce),
    .din({sleep_req, link_pass, irq_level_strap}),
    .dout(pins_s)
  );

  // synchronised pin levels, named by what they carry
  logic irq_lvl_s;
  logic link_s;
  logic sleep_s;
  assign irq_lvl_s = pins_s[0];
  assign link_s = pins_s[1];
  assign sleep_s = pins_s[2];

  // register and bus state
  logic [15:0] cfg_q, cfg_d;
  logic aw_got_q, aw_got_d;
  logic w_got_q, w_got_d;
  logic [ADDR_W-1:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;
  logic [15:0] rd_word;
  logic [15:0] wr_new;
  logic do_write;

  // read word assembly: irq style flag comes from the strap only
  always_comb begin
    rd_word = cfg_q;
    rd_word[BMCFG_B_IRQSTYLE] = irq_lvl_s; // R2
  end

  // write channels are taken in either order, response after both
  // each item is captured here at the same edge that its ready pulse goes out
  always_comb begin
    aw_got_d = aw_got_q;
    w_got_d = w_got_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    cfg_d = cfg_q;
    wr_new = cfg_q;
    do_write = 1'b0;
    if (s_axi_awvalid && !aw_got_q && !bvalid_q) begin
      aw_got_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_got_q && !bvalid_q) begin
      w_got_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    if (aw_got_q && w_got_q) begin
      do_write = 1'b1;
      aw_got_d = 1'b0;
      w_got_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = BMCFG_RESP_OKAY;
      if (awaddr_q[ADDR_W-1:2] == BMCFG_OFF_CFG[ADDR_W-1:2]) begin
        if (wstrb_q[0]) begin
          wr_new[7:0] = wdata_q[7:0];
        end
        if (wstrb_q[1]) begin
          wr_new[15:8] = wdata_q[15:8];
        end
        // only documented writable bits change; bit 7 stays read-only
        cfg_d = (cfg_q & ~BMCFG_WR_MASK) | (wr_new & BMCFG_WR_MASK); // R2
      end else if (awaddr_q[ADDR_W-1:2] != BMCFG_OFF_STAT[ADDR_W-1:2]) begin
        bresp_d = BMCFG_RESP_SLVERR;
      end
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
  end

  // read channel: one cycle to rvalid, held until rready
  // read data are captured with rvalid and stand until rready
  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end else if (s_axi_arvalid && !rvalid_q) begin
      rvalid_d = 1'b1;
      rresp_d = BMCFG_RESP_OKAY;
      if (s_axi_araddr[ADDR_W-1:2] == BMCFG_OFF_CFG[ADDR_W-1:2]) begin
        rdata_d = {16'h0000, rd_word};
      end else if (s_axi_araddr[ADDR_W-1:2] ==
                   BMCFG_OFF_STAT[ADDR_W-1:2]) begin
        rdata_d = {29'h0000000, sleep_s, aui_active, link_s};
      end else begin
        rdata_d = 32'h00000000;
        rresp_d = BMCFG_RESP_SLVERR;
      end
    end
  end

  // write side and register flip-flops
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= BMCFG_RST_CFG;
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= BMCFG_RESP_OKAY;
    end else if (ce) begin
      cfg_q <= cfg_d;
      aw_got_q <= aw_got_d;
      w_got_q <= w_got_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
    end
  end

  // read side flip-flops
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= BMCFG_RESP_OKAY;
    end else if (ce) begin
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  // ready signals registered; one pulse per accepted item
  // ready drops after one pulse so one item is never taken twice
  logic awready_d, wready_d, arready_d;
  always_comb begin
    awready_d = s_axi_awvalid && !aw_got_q && !bvalid_q && !s_axi_awready;
    wready_d = s_axi_wvalid && !w_got_q && !bvalid_q && !s_axi_wready;
    arready_d = s_axi_arvalid && !rvalid_q && !s_axi_arready;
  end

  // media decode and option outputs
  logic aui_d;
  logic [15:0] c;
  assign c = cfg_q;

  // soft and auto choices come from other logic on this clock
  always_comb begin
    case (bmcfg_med_t'(c[BMCFG_B_MEDIA_SELECT +: 2]))
      BMCFG_MED_SOFT: aui_d = mode_reg_aui; // R10
      BMCFG_MED_TP: aui_d = 1'b0; // R10
      BMCFG_MED_AUTO: aui_d = auto_aui; // R10
      BMCFG_MED_AUI: aui_d = 1'b1; // R10
      default: aui_d = 1'b0;
    endcase
  end

  // gated strobes and option levels, next values
  logic prom_en_d, flash_en_d, stag_d, conv_d, wake_d, led_d;

  always_comb begin
    prom_en_d = prom_wr_req && c[BMCFG_B_UNLOCK]; // R1
    flash_en_d = flash_wr_req && c[BMCFG_B_UNLOCK]; // R1
    // stagger only in bus master cycles with the bit clear
    stag_d = bus_master && !c[BMCFG_B_NOSTAG]; // R3 R4
    // low enables converter; deselect bit or tp medium forces high
    conv_d = c[BMCFG_B_CONVDESEL] || !aui_d; // R5 R6
    // wake receiver only with bit set, tp medium, in sleep
    wake_d = c[BMCFG_B_WAKE] && !aui_d && sleep_s; // R7 R9
    led_d = !link_s; // R8
  end

  // bus ready flip-flops
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_arready <= 1'b0;
    end else if (ce) begin
      s_axi_awready <= awready_d;
      s_axi_wready <= wready_d;
      s_axi_arready <= arready_d;
    end
  end

  // option output flip-flops
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prom_wr_en <= 1'b0;
      flash_wr_en <= 1'b0;
      data_drive_stagger <= 1'b0;
      converter_select_out <= 1'b1;
      tp_rx_sleep_on <= 1'b0;
      link_indicator <= 1'b1;
      aui_active <= 1'b0;
      media_select <= BMCFG_MED_AUTO;
    end else if (ce) begin
      prom_wr_en <= prom_en_d;
      flash_wr_en <= flash_en_d;
      data_drive_stagger <= stag_d;
      converter_select_out <= conv_d;
      tp_rx_sleep_on <= wake_d;
      link_indicator <= led_d;
      aui_active <= aui_d;
      media_select <= c[BMCFG_B_MEDIA_SELECT +: 2];
    end
  end

  // response channels come straight from their flip-flops
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
endmodule
`default_nettype wire

// *** sim/bmcfg_top_monitor.sv ***
// Purpose: port assertions for the option bits bank
// Assumes: ce is held high
// Notes: bound into bmcfg_top after the module
`timescale 1ns/1ns
`default_nettype none
module bmcfg_top_monitor (
  input wire logic sys_clk, // clock
  input wire logic nrst, // reset, active low
  input wire logic link_pass, // link pin
  input wire logic prom_wr_req, // store write request
  input wire logic flash_wr_req, // flash write request
  input wire logic bus_master, // bus master cycle running
  input wire logic prom_wr_en, // gated store strobe
  input wire logic flash_wr_en, // gated flash strobe
  input wire logic data_drive_stagger, // stagger output
  input wire logic converter_select_out, // converter select
  input wire logic aui_active, // aui in use
  input wire logic tp_rx_sleep_on, // receiver kept on
  input wire logic link_indicator, // link, active low
  input wire logic [1:0] media_select // media field
);
  // cycles since reset, saturating
  logic [3:0] up_q;
  logic [3:0] up_d;
  always_comb up_d = (up_q == 4'hf) ? up_q : up_q + 4'h1;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) up_q <= 4'h0;
    else up_q <= up_d;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // strobes only follow a request, outputs follow the config
  property p_prom; prom_wr_en |-> $past(prom_wr_req); endproperty
  a_prom: assert property (p_prom) else $error("store strobe");
  property p_flash; flash_wr_en |-> $past(flash_wr_req); endproperty
  a_flash: assert property (p_flash) else $error("flash strobe");
  property p_stag; data_drive_stagger |-> $past(bus_master); endproperty
  a_stag: assert property (p_stag) else $error("stagger");
  property p_conv;
    !converter_select_out |-> aui_active || $past(aui_active);
  endproperty
  a_conv: assert property (p_conv) else $error("converter on");
  property p_aui; (media_select == 2'h3) [*2] |-> aui_active; endproperty
  a_aui: assert property (p_aui) else $error("aui forced");
  property p_tp; (media_select == 2'h1) [*2] |-> !aui_active; endproperty
  a_tp: assert property (p_tp) else $error("tp forced");
  property p_wake;
    tp_rx_sleep_on |-> media_select != 2'h3 || $past(media_select) != 2'h3;
  endproperty
  a_wake: assert property (p_wake) else $error("wake on aui");
  property p_link;
    (up_q == 4'hf && link_pass) [*6] |-> !link_indicator;
  endproperty
  a_link: assert property (p_link) else $error("link shown");
  c_prom: cover property (prom_wr_en);
  c_link: cover property (!link_indicator);
  c_stag: cover property (data_drive_stagger);
endmodule
bind bmcfg_top bmcfg_top_monitor i_bmcfg_top_monitor (.sys_clk, .nrst,
  .link_pass, .prom_wr_req, .flash_wr_req, .bus_master, .prom_wr_en,
  .flash_wr_en, .data_drive_stagger, .converter_select_out, .aui_active,
  .tp_rx_sleep_on, .link_indicator, .media_select);
`default_nettype wire

// *** sim/bmcfg_top_tb.sv ***
// Purpose: self-checking bench for the option bits bank
// Assumes: ce held high, design clocked at 100 MHz
// Notes: outputs sampled at the edge before updates land
`timescale 1ns/1ns
`default_nettype none
module bmcfg_top_tb;
  import bmcfg_pkg::*;
  logic sys_clk = '0, nrst = '0, ce = '1, irq_level_strap = '1;
  logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
  logic s_axi_arvalid = '0, s_axi_rready = '0, link_pass = '0;
  logic sleep_req = '0, mode_reg_aui = '0, auto_aui = '0;
  logic bus_master = '0, prom_wr_req = '0, flash_wr_req = '0;
  logic [3:0] s_axi_awaddr = '0, s_axi_araddr = '0, s_axi_wstrb = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp, media_select;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, prom_wr_en, flash_wr_en, data_drive_stagger;
  logic converter_select_out, tp_rx_sleep_on, link_indicator, aui_active;
  int n_mismatch = 0, compares = 0, cyc = 0;
  always #5 sys_clk = ~sys_clk;
  bmcfg_top i_bmcfg_top (.sys_clk, .nrst, .ce, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .irq_level_strap, .link_pass, .sleep_req, .mode_reg_aui, .auto_aui,
    .bus_master, .prom_wr_req, .flash_wr_req, .prom_wr_en, .flash_wr_en,
    .data_drive_stagger, .converter_select_out, .tp_rx_sleep_on,
    .link_indicator, .aui_active, .media_select);
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // one write, address and data offered together
  task automatic wr(input logic [3:0] a, input logic [31:0] d,
    input logic [3:0] s, input logic [1:0] r);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= '1;
    s_axi_wvalid <= '1;
    s_axi_bready <= '1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= '0;
      if (s_axi_wready) s_axi_wvalid <= '0;
    end while (!s_axi_bvalid);
    s_axi_bready <= '0;
    chk(s_axi_bresp, r);
  endtask
  // one read, data taken at the handshake edge
  task automatic rd(input logic [3:0] a, input logic [31:0] e,
    input logic [1:0] r);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= '1;
    s_axi_rready <= '1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= '0;
    end while (!s_axi_rvalid);
    s_axi_rready <= '0;
    chk(s_axi_rdata, e);
    chk(s_axi_rresp, r);
  endtask
  task automatic t_mask;
    rd(4'h0, BMCFG_RST_CFG | 16'h80, BMCFG_RESP_OKAY);
    bus_master <= '1;
    wt(2);
    chk(data_drive_stagger, 32'h1);
    bus_master <= '0;
    wr(4'h0, 32'hffff, 4'hf, BMCFG_RESP_OKAY);
    rd(4'h0, BMCFG_WR_MASK | 16'h80, BMCFG_RESP_OKAY);
    irq_level_strap <= '0;
    wt(6);
    rd(4'h0, BMCFG_WR_MASK, BMCFG_RESP_OKAY);
    irq_level_strap <= '1;
  endtask
  // every media code with both sources of the soft and auto choice
  task automatic t_media;
    logic a;
    for (int k = 0; k < 2; k++) begin
      for (int m = 0; m < 4; m++) begin
        mode_reg_aui <= k[0];
        auto_aui <= !k[0];
        wr(4'h0, m, 4'hf, BMCFG_RESP_OKAY);
        wt(3);
        a = m == 3 || (m == 0 && k == 1) || (m == 2 && k == 0);
        chk(media_select, m);
        chk(aui_active, a);
        chk(converter_select_out, !a);
      end
    end
    wr(4'h0, 32'h23, 4'hf, BMCFG_RESP_OKAY);
    wt(3);
    chk(converter_select_out, 32'h1);
  endtask
  task automatic t_gates;
    prom_wr_req <= '1;
    flash_wr_req <= '1;
    bus_master <= '1;
    wr(4'h0, 32'h2, 4'hf, BMCFG_RESP_OKAY);
    wt(3);
    chk({prom_wr_en, flash_wr_en, data_drive_stagger}, 32'h1);
    wr(4'h0, 32'h142, 4'hf, BMCFG_RESP_OKAY);
    wt(3);
    chk({prom_wr_en, flash_wr_en, data_drive_stagger}, 32'h6);
    bus_master <= '0;
  endtask
  task automatic t_wake;
    sleep_req <= '1;
    wr(4'h0, 32'h5, 4'hf, BMCFG_RESP_OKAY);
    wt(6);
    chk(tp_rx_sleep_on, 32'h1);
    wr(4'h0, 32'h7, 4'hf, BMCFG_RESP_OKAY);
    wt(3);
    chk(tp_rx_sleep_on, 32'h0);
    wr(4'h0, 32'h1, 4'hf, BMCFG_RESP_OKAY);
    wt(3);
    chk(tp_rx_sleep_on, 32'h0);
    sleep_req <= '0;
  endtask
  task automatic t_bus;
    link_pass <= '1;
    wt(6);
    chk(link_indicator, 32'h0);
    rd(4'h4, 32'h1, BMCFG_RESP_OKAY);
    wr(4'h0, 32'h101, 4'hf, BMCFG_RESP_OKAY);
    wr(4'h4, 32'hffff, 4'hf, BMCFG_RESP_OKAY);
    wr(4'h8, 32'hffff, 4'hf, BMCFG_RESP_SLVERR);
    rd(4'h8, 32'h0, BMCFG_RESP_SLVERR);
    rd(4'h0, 32'h181, BMCFG_RESP_OKAY);
    wr(4'h0, 32'h0, 4'h2, BMCFG_RESP_OKAY);
    rd(4'h0, 32'h81, BMCFG_RESP_OKAY);
    link_pass <= '0;
    wt(6);
    chk(link_indicator, 32'h1);
  endtask
  task automatic print_verdict;
    if (n_mismatch == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // cut a hang short
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      print_verdict;
    end
  end
  initial begin
    wt(16);
    nrst <= '1;
    wt(3);
    t_mask;
    t_media;
    t_gates;
    t_wake;
    t_bus;
    print_verdict;
  end
endmodule
`default_nettype wire
